/* inc/bltfc_pkg.sv */
package bltfc_pkg;

   // Core clock and derived time bases
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned SUBTICK_NS = 100_000;
   localparam int unsigned SUBTICK_CYCLES = CLK_HZ / 1_000_000 * SUBTICK_NS / 1_000;
   localparam int unsigned SUBTICKS_PER_SEC = 1_000_000_000 / SUBTICK_NS;
   localparam int unsigned SUBTICKS_PER_MS = 1_000_000 / SUBTICK_NS;
   localparam int unsigned FULL_SCALE_STEPS = 127;
   localparam int unsigned CUBIC_SHIFT = 7;

   // Fade durations in ms for a full-scale change
   localparam int unsigned FADE_FAST_MS = 100;
   localparam int unsigned FADE_STEP_MS = 300;
   localparam int unsigned FADE_LINEAR_LAST = 10;
   localparam int unsigned FADE_TAIL_BASE_MS = 3_000;
   localparam int unsigned FADE_TAIL_STEP_MS = 500;

   // Register offsets
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_SINK = 8'h05;
   localparam logic [7:0] ADDR_OFF = 8'h06;
   localparam logic [7:0] ADDR_DIM = 8'h07;
   localparam logic [7:0] ADDR_FADE = 8'h08;

   // Field positions and reset values
   localparam int unsigned OVERRIDE_BIT = 0;
   localparam int unsigned LAW_LSB = 1;
   localparam int unsigned FI_LSB = 0;
   localparam int unsigned FO_LSB = 4;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [6:0] LEVEL_ZERO = 7'h00;
   localparam logic [6:0] TIMEOUT_OFF = 7'h00;
   localparam logic [3:0] FADE_CODE_FAST = 4'h0;

   typedef enum logic [1:0] {
      LAW_LINEAR = 2'h0,
      LAW_SQUARE = 2'h1,
      LAW_CUBIC_A = 2'h2,
      LAW_CUBIC_B = 2'h3
   } bltfc_law_t;

   // Programmed configuration travels as one bundle
   typedef struct packed {
      logic [6:0] sink_sel;
      logic [6:0] off_t;
      logic [6:0] dim_t;
      logic [3:0] fade_out;
      logic [3:0] fade_in;
      bltfc_law_t law;
      logic fade_override;
   } bltfc_cfg_t;

   // Full-scale fade time for a rate code
   function automatic int unsigned bltfc_fade_ms(input logic [3:0] code);
      int unsigned c;
      c = int'(code);
      if (c == 0) return FADE_FAST_MS;
      if (c <= FADE_LINEAR_LAST) return c * FADE_STEP_MS;
      return FADE_TAIL_BASE_MS + (c - FADE_LINEAR_LAST) * FADE_TAIL_STEP_MS;
   endfunction : bltfc_fade_ms

   // Subticks between two one-code steps, never below one
   function automatic logic [15:0] bltfc_step_len(input logic [3:0] code);
      int unsigned t;
      t = bltfc_fade_ms(code) * SUBTICKS_PER_MS / FULL_SCALE_STEPS;
      if (t == 0) t = 1;
      return 16'(t);
   endfunction : bltfc_step_len

endpackage : bltfc_pkg

/* rtl/bltfc_ctrl.sv */
`timescale 1ns/100ps
// How it works
// - Law 00 linear DAC, 01 square DAC
// - Law 10 and 11 square, two cubic profiles
// - Config bit 0 enables fade override
// - Sink bit set makes LED independent
// - Sink bit clear follows common backlight
// - Off timeout seconds, zero disables it
// - Off countdown starts after dim expires, or at maximum current when dim is zero
// - Dim timeout seconds drops to dim current
// - Dim countdown starts at maximum current
// - Nonzero fade-out ramps down to target
// - Nonzero fade-in ramps up to maximum
// - Code zero still ramps, about 100 ms
// - Fade-out codes 0.3 s steps to 3 s, then 0.5 s steps to 5.5 s
// - Fade-in shares scale, up to 5.5 s
// - Times are full scale, shorter proportionally
// - Backlight on needs enable and standby pin
// - Sync enable ignored when per-sink enable set
module bltfc_ctrl
   import bltfc_pkg::*;
#(
   parameter int unsigned SUBTICK_LEN = SUBTICK_CYCLES, // Cycles per 100 us subtick
   parameter int unsigned NUM_SINKS = 7 // Fixed by the sink register layout
)(
   input wire logic core_clk, // 50 MHz core clock
   input wire logic rst_n, // Async reset, active low
   input wire logic [7:0] reg_addr, // Register offset
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe, one cycle
   input wire logic reg_rd, // Read strobe, one cycle
   output logic [7:0] reg_rdata, // Read data, valid cycle after strobe
   input wire logic backlight_on, // Mode control backlight enable
   input wire logic standby_release_pin, // Standby pin, high when running
   input wire logic independent_sinks_on, // Mode control sync sink enable
   input wire logic [6:0] sink_independent_en, // Per-sink independent enables
   input wire logic [6:0] max_current_code, // Maximum backlight DAC code
   input wire logic [6:0] dim_current_code, // Dim backlight DAC code
   output logic [6:0] bl_dac_code, // Present backlight DAC code
   output logic dac_square_law, // High selects square-law DAC
   output logic [6:0] sink_on, // Per-sink on
   output logic bl_dimmed, // Backlight at dim stage
   output logic bl_timed_out // Backlight off by timeout
);

   // Parameter sanity
   // The subtick divider is sixteen bits wide
   if (SUBTICK_LEN < 1 || SUBTICK_LEN > 65536) begin : g_bad_tick
      $error("SUBTICK_LEN must lie between 1 and 65536");
   end
   if (NUM_SINKS != 7) begin : g_bad_sinks
      $error("NUM_SINKS must be 7");
   end

   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_RISE = 5'h02,
      ST_FULL = 5'h04,
      ST_DIM = 5'h08,
      ST_TOUT = 5'h10
   } bltfc_state_t;

   bltfc_cfg_t cfg;
   bltfc_cfg_t next_cfg;
   logic [7:0] next_rdata;

   // Register writes; reserved bits are dropped so they read back as zero
   always_comb begin
      next_cfg = cfg;
      next_rdata = reg_rdata;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_CONFIG: begin
               next_cfg.fade_override = reg_wdata[OVERRIDE_BIT];
               next_cfg.law = bltfc_law_t'(reg_wdata[LAW_LSB +: 2]);
            end
            ADDR_SINK: next_cfg.sink_sel = reg_wdata[6:0];
            ADDR_OFF: next_cfg.off_t = reg_wdata[6:0];
            ADDR_DIM: next_cfg.dim_t = reg_wdata[6:0];
            ADDR_FADE: begin
               next_cfg.fade_in = reg_wdata[FI_LSB +: 4];
               next_cfg.fade_out = reg_wdata[FO_LSB +: 4];
            end
            default: next_cfg = cfg;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            ADDR_CONFIG: next_rdata = {5'h00, cfg.law, cfg.fade_override};
            ADDR_SINK: next_rdata = {1'b0, cfg.sink_sel};
            ADDR_OFF: next_rdata = {1'b0, cfg.off_t};
            ADDR_DIM: next_rdata = {1'b0, cfg.dim_t};
            ADDR_FADE: next_rdata = {cfg.fade_out, cfg.fade_in};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= bltfc_cfg_t'(0);
         reg_rdata <= REG_RESET;
      end else begin
         cfg <= next_cfg;
         reg_rdata <= next_rdata;
      end
   end

   // Subtick and one-second dividers; the second runs free, so a timeout
   // may fire up to one second early relative to its start
   logic [15:0] sub_cnt;
   logic [15:0] next_sub_cnt;
   logic [13:0] sec_cnt;
   logic [13:0] next_sec_cnt;
   logic sub_tick;
   logic next_sub_tick;
   logic sec_tick;
   logic next_sec_tick;

   always_comb begin
      next_sub_cnt = sub_cnt + 16'h0001;
      next_sub_tick = 1'b0;
      next_sec_cnt = sec_cnt;
      next_sec_tick = 1'b0;
      if (sub_cnt == 16'(SUBTICK_LEN - 1)) begin
         next_sub_cnt = 16'h0000;
         next_sub_tick = 1'b1;
         next_sec_cnt = sec_cnt + 14'h0001;
         if (sec_cnt == 14'(SUBTICKS_PER_SEC - 1)) begin
            next_sec_cnt = 14'h0000;
            next_sec_tick = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sub_cnt <= 16'h0000;
         sec_cnt <= 14'h0000;
         sub_tick <= 1'b0;
         sec_tick <= 1'b0;
      end else begin
         sub_cnt <= next_sub_cnt;
         sec_cnt <= next_sec_cnt;
         sub_tick <= next_sub_tick;
         sec_tick <= next_sec_tick;
      end
   end

   // Timeout counters
   bltfc_state_t state;
   bltfc_state_t next_state;
   logic dim_run;
   logic off_run;
   logic dim_expired;
   logic off_expired;

   assign dim_run = (state == ST_FULL);
   assign off_run = (state == ST_DIM) || (state == ST_FULL && cfg.dim_t == TIMEOUT_OFF);

   bltfc_timeout u_dim_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .run(dim_run),
      .sec_tick(sec_tick),
      .period(cfg.dim_t),
      .expired(dim_expired)
   );

   bltfc_timeout u_off_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .run(off_run),
      .sec_tick(sec_tick),
      .period(cfg.off_t),
      .expired(off_expired)
   );

   // Sequencer: full only once the ramp has landed on the maximum
   logic bl_enable;
   logic [6:0] level;
   logic [6:0] next_level;
   logic [6:0] target;

   assign bl_enable = backlight_on && standby_release_pin;

   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: if (bl_enable) next_state = ST_RISE;
         ST_RISE: begin
            if (!bl_enable) next_state = ST_OFF;
            else if (level == max_current_code) next_state = ST_FULL;
         end
         ST_FULL: begin
            if (!bl_enable) next_state = ST_OFF;
            else if (dim_expired) next_state = ST_DIM;
            else if (off_expired) next_state = ST_TOUT;
         end
         ST_DIM: begin
            if (!bl_enable) next_state = ST_OFF;
            else if (off_expired) next_state = ST_TOUT;
         end
         ST_TOUT: if (!bl_enable) next_state = ST_OFF;
         default: next_state = ST_OFF;
      endcase
   end

   always_comb begin
      case (state)
         ST_RISE, ST_FULL: target = max_current_code;
         ST_DIM: target = dim_current_code;
         default: target = LEVEL_ZERO;
      endcase
   end

   // Ramp step length: one code per step, so a short change ends sooner
   logic rising;
   logic [3:0] step_code;
   logic [15:0] base_len;
   logic [22:0] cubic_prod;
   logic [6:0] cubic_weight;
   logic [15:0] step_len;
   logic [15:0] step_cnt;
   logic [15:0] next_step_cnt;

   assign rising = (target > level);
   // Override trades the programmed rate for the fast one
   assign step_code = cfg.fade_override ? FADE_CODE_FAST
      : (rising ? cfg.fade_in : cfg.fade_out);
   assign base_len = bltfc_step_len(step_code);
   assign cubic_weight = (cfg.law == LAW_CUBIC_A) ? level : ~level;
   assign cubic_prod = 23'(base_len) * 23'(cubic_weight);

   // Cubic laws stretch steps at one end of the range; linear steps stay even
   always_comb begin
      if (cfg.law[1]) begin
         step_len = base_len + cubic_prod[CUBIC_SHIFT +: 16];
      end else begin
         step_len = base_len;
      end
   end

   always_comb begin
      next_level = level;
      next_step_cnt = step_cnt;
      if (level == target) begin
         next_step_cnt = 16'h0000;
      end else if (sub_tick) begin
         if (step_cnt + 16'h0001 >= step_len) begin
            next_step_cnt = 16'h0000;
            next_level = rising ? level + 7'h01 : level - 7'h01;
         end else begin
            next_step_cnt = step_cnt + 16'h0001;
         end
      end
   end

   // Sink steering; common sinks follow the shared ramp
   logic any_indep;
   logic [6:0] next_sink_on;

   assign any_indep = |sink_independent_en;

   always_comb begin
      for (int i = 0; i < NUM_SINKS; i++) begin
         if (cfg.sink_sel[i]) begin
            next_sink_on[i] = any_indep ? sink_independent_en[i] : independent_sinks_on;
         end else begin
            next_sink_on[i] = (level != LEVEL_ZERO);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_OFF;
         level <= LEVEL_ZERO;
         step_cnt <= 16'h0000;
         sink_on <= 7'h00;
         bl_dac_code <= LEVEL_ZERO;
         dac_square_law <= 1'b0;
         bl_dimmed <= 1'b0;
         bl_timed_out <= 1'b0;
      end else begin
         state <= next_state;
         level <= next_level;
         step_cnt <= next_step_cnt;
         sink_on <= next_sink_on;
         bl_dac_code <= next_level;
         dac_square_law <= (cfg.law != LAW_LINEAR);
         bl_dimmed <= (next_state == ST_DIM);
         bl_timed_out <= (next_state == ST_TOUT);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_linear_law;
      cfg.law == LAW_LINEAR |=> !dac_square_law;
   endproperty
   a_linear_law: assert property (p_linear_law) else $error("linear law not driven");

   property p_cubic_law;
      cfg.law[1] |=> dac_square_law;
   endproperty
   a_cubic_law: assert property (p_cubic_law) else $error("cubic law lacks square DAC");

   property p_sink_indep;
      cfg.sink_sel[0] && !any_indep |=> sink_on[0] == $past(independent_sinks_on);
   endproperty
   a_sink_indep: assert property (p_sink_indep) else $error("independent sink wrong");

   property p_sink_per_enable;
      cfg.sink_sel[1] && any_indep |=> sink_on[1] == $past(sink_independent_en[1]);
   endproperty
   a_sink_per_enable: assert property (p_sink_per_enable) else $error("sync enable not ignored");

   property p_sink_common;
      !cfg.sink_sel[2] |=> sink_on[2] == ($past(level) != LEVEL_ZERO);
   endproperty
   a_sink_common: assert property (p_sink_common) else $error("common sink not following");

   property p_needs_pin;
      !standby_release_pin |=> state == ST_OFF;
   endproperty
   a_needs_pin: assert property (p_needs_pin) else $error("backlight on in standby");

   property p_dim_from_full;
      state == ST_DIM && $past(state) != ST_DIM |-> $past(state) == ST_FULL;
   endproperty
   a_dim_from_full: assert property (p_dim_from_full) else $error("dim entered early");

   property p_off_after_dim;
      state == ST_TOUT && $past(state) != ST_TOUT && $past(cfg.dim_t) != TIMEOUT_OFF
         |-> $past(state) == ST_DIM;
   endproperty
   a_off_after_dim: assert property (p_off_after_dim) else $error("off before dim");

   property p_zero_timeouts;
      state == ST_FULL && cfg.off_t == TIMEOUT_OFF && cfg.dim_t == TIMEOUT_OFF
         |=> state != ST_TOUT && state != ST_DIM;
   endproperty
   a_zero_timeouts: assert property (p_zero_timeouts) else $error("disabled timeout fired");

   property p_single_step;
      level != $past(level) |-> $past(sub_tick)
         && (level == $past(level) + 7'h01 || level == $past(level) - 7'h01);
   endproperty
   a_single_step: assert property (p_single_step) else $error("ramp jumped");

   // The fast rate still takes several subticks per code, so it never jumps
   property p_fast_step;
      step_code == FADE_CODE_FAST && !cfg.law[1]
         |-> step_len == 16'(FADE_FAST_MS * SUBTICKS_PER_MS / FULL_SCALE_STEPS);
   endproperty
   a_fast_step: assert property (p_fast_step) else $error("fast ramp step wrong");

endmodule : bltfc_ctrl

/* rtl/bltfc_timeout.sv */
`timescale 1ns/100ps
module bltfc_timeout
   import bltfc_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic rst_n, // Async reset, active low
   input wire logic run, // Count while high, reload while low
   input wire logic sec_tick, // One-second enable pulse
   input wire logic [6:0] period, // Seconds, zero never expires
   output logic expired // Level, stays until run drops
);

   logic [6:0] cnt;
   logic [6:0] next_cnt;
   logic next_expired;

   // Reload whenever idle so each new sequence starts from the full period
   always_comb begin
      next_cnt = cnt;
      next_expired = expired;
      if (!run) begin
         next_cnt = period;
         next_expired = 1'b0;
      end else if (sec_tick && cnt != TIMEOUT_OFF) begin
         next_cnt = cnt - 7'h01;
         if (cnt == 7'h01) begin
            next_expired = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= TIMEOUT_OFF;
         expired <= 1'b0;
      end else begin
         cnt <= next_cnt;
         expired <= next_expired;
      end
   end

   property p_idle_clears;
      @(posedge core_clk) disable iff (!rst_n)
      !run |=> !expired;
   endproperty
   a_idle_clears: assert property (p_idle_clears) else $error("timeout flag kept while idle");

endmodule : bltfc_timeout

/* testbench/bltfc_ctrl_bench.sv */
`timescale 1ns/100ps
module bltfc_ctrl_bench
   import bltfc_pkg::*;
;
   localparam int unsigned SUB = 2; // Short subtick keeps one second at 20000 cycles
   localparam int unsigned FAST = FADE_FAST_MS * SUBTICKS_PER_MS / FULL_SCALE_STEPS;
   // Law 11 step taken from level 2: weight is full scale less two
   localparam int unsigned CUBIC_EXP = FAST + FAST * (FULL_SCALE_STEPS - 2) / (1 << CUBIC_SHIFT);
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic backlight_on = 1'b0;
   logic standby_release_pin = 1'b0;
   logic independent_sinks_on = 1'b0;
   logic [6:0] sink_independent_en = 7'h00;
   logic [6:0] max_current_code = 7'h10;
   logic [6:0] dim_current_code = 7'h04;
   logic [6:0] bl_dac_code;
   logic dac_square_law;
   logic [6:0] sink_on;
   logic bl_dimmed;
   logic bl_timed_out;
   int errors = 0;
   int cmp_count = 0;
   int n;
   int t0;

   // Clock at 50 MHz
   always #10 core_clk = ~core_clk;

   bltfc_ctrl #(.SUBTICK_LEN(SUB), .NUM_SINKS(7)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .backlight_on(backlight_on),
      .standby_release_pin(standby_release_pin), .independent_sinks_on(independent_sinks_on),
      .sink_independent_en(sink_independent_en), .max_current_code(max_current_code),
      .dim_current_code(dim_current_code), .bl_dac_code(bl_dac_code),
      .dac_square_law(dac_square_law), .sink_on(sink_on), .bl_dimmed(bl_dimmed),
      .bl_timed_out(bl_timed_out)
   );

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask : check8

   // Inputs move on the falling edge only, away from the sampling edge
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      @(negedge core_clk);
      check8(reg_rdata, exp);
   endtask : reg_read

   // Bounded wait for the ramp to reach a code
   task automatic wait_code(input logic [6:0] c, input int lim);
      n = 0;
      while (bl_dac_code !== c && n < lim) begin
         cyc(1);
         n++;
      end
   endtask : wait_code

   task automatic wait_change(input int lim);
      logic [6:0] old;
      old = bl_dac_code;
      n = 0;
      while (bl_dac_code === old && n < lim) begin
         cyc(1);
         n++;
      end
   endtask : wait_change

   // Watchdog sized above the roughly 64000 cycles of the sequence
   initial begin
      repeat (90000) @(posedge core_clk);
      errors++;
      close_out();
   end

   initial begin
      cyc(10);
      rst_n = 1'b1;
      // Reset values and unmapped place
      for (int a = 4; a <= 9; a++) begin
         reg_read(8'(a), 8'h00);
      end
      // Reserved bits read back as zero
      reg_write(ADDR_CONFIG, 8'hFF);
      reg_write(ADDR_SINK, 8'hFF);
      reg_write(ADDR_OFF, 8'hFF);
      reg_write(ADDR_DIM, 8'hFF);
      reg_write(ADDR_FADE, 8'hA5);
      reg_write(8'h09, 8'h3C);
      reg_read(ADDR_CONFIG, 8'h07);
      reg_read(ADDR_SINK, 8'h7F);
      reg_read(ADDR_OFF, 8'h7F);
      reg_read(ADDR_DIM, 8'h7F);
      reg_read(ADDR_FADE, 8'hA5);
      reg_read(8'h09, 8'h00);
      // Every transfer law code selects its DAC kind
      for (int l = 0; l < 4; l++) begin
         reg_write(ADDR_CONFIG, 8'(l << 1));
         cyc(2);
         check8({7'h00, dac_square_law}, {7'h00, l != 0});
      end
      // Independent sinks: sync enable, then per-sink enables win
      reg_write(ADDR_SINK, 8'h0F);
      independent_sinks_on = 1'b1;
      cyc(3);
      check8({1'b0, sink_on}, 8'h0F);
      sink_independent_en = 7'h05;
      cyc(3);
      check8({1'b0, sink_on}, 8'h05);
      independent_sinks_on = 1'b0;
      sink_independent_en = 7'h00;
      cyc(3);
      check8({1'b0, sink_on}, 8'h00);
      // Enable without the standby pin keeps the backlight dark
      reg_write(ADDR_CONFIG, 8'h01);
      reg_write(ADDR_FADE, 8'hFF);
      reg_write(ADDR_DIM, 8'h01);
      reg_write(ADDR_OFF, 8'h01);
      backlight_on = 1'b1;
      cyc(200);
      check8({1'b0, bl_dac_code}, 8'h00);
      // Override forces the fast ramp despite the slowest rate code
      standby_release_pin = 1'b1;
      cyc(60);
      check8({7'h00, bl_dac_code > 0 && bl_dac_code < 7'h10}, 8'h01);
      wait_code(7'h10, 600);
      check8({1'b0, bl_dac_code}, 8'h10);
      check8({1'b0, sink_on}, 8'h70);
      check8({6'h00, bl_timed_out, bl_dimmed}, 8'h00);
      // Dim first, then the off countdown
      n = 0;
      while (bl_dimmed !== 1'b1 && n < 21000) begin
         cyc(1);
         n++;
      end
      check8({7'h00, bl_dimmed}, 8'h01);
      check8({7'h00, bl_timed_out}, 8'h00);
      wait_code(7'h04, 600);
      check8({1'b0, bl_dac_code}, 8'h04);
      n = 0;
      while (bl_timed_out !== 1'b1 && n < 21000) begin
         cyc(1);
         n++;
      end
      check8({7'h00, bl_timed_out}, 8'h01);
      wait_code(7'h00, 600);
      check8({1'b0, bl_dac_code}, 8'h00);
      // Sink outputs follow the level one cycle later
      cyc(1);
      check8({1'b0, sink_on}, 8'h00);
      // Drop the enable; restart with timeouts disabled and a slow linear rate
      backlight_on = 1'b0;
      reg_write(ADDR_CONFIG, 8'h00);
      reg_write(ADDR_FADE, 8'h11);
      reg_write(ADDR_DIM, 8'h00);
      reg_write(ADDR_OFF, 8'h00);
      cyc(5);
      backlight_on = 1'b1;
      wait_change(2000);
      wait_change(2000);
      t0 = $time;
      wait_change(2000);
      // Code 1 means 300 ms full scale, that is 23 subticks a step
      check8(8'((($time - t0) / 20) / SUB), 8'(3000 / 127));
      wait_code(7'h10, 2000);
      check8({1'b0, bl_dac_code}, 8'h10);
      cyc(22000);
      check8({6'h00, bl_timed_out, bl_dimmed}, 8'h00);
      check8({1'b0, bl_dac_code}, 8'h10);
      // Enable drop at full level returns to dark
      backlight_on = 1'b0;
      wait_code(7'h00, 1000);
      check8({1'b0, bl_dac_code}, 8'h00);
      // Cubic 11 stretches the fast step near the bottom of the range
      reg_write(ADDR_CONFIG, 8'h06);
      reg_write(ADDR_FADE, 8'h00);
      backlight_on = 1'b1;
      wait_change(2000);
      wait_change(2000);
      t0 = $time;
      wait_change(2000);
      check8(8'((($time - t0) / 20) / SUB), 8'(CUBIC_EXP));
      close_out();
   end
endmodule : bltfc_ctrl_bench
